// [edc_top.sv]
/*
 * Event driven up/down counter: register port, counting clock divider, input synchronisers,
 * latch event detectors and one or two counter units.
 * Assumes event and latch pins are asynchronous to CORE_CLK_I; the register master
 * is on CORE_CLK_I and never needs to wait.
 */
// Operation
// - latch output 0 feeds capture of unit 0, output 1 feeds unit 1 only.
// - 16-bit build has two counter units, 32-bit build has one.
// - terminal inputs are evaluated and count updated once per counting tick; capture inputs act on every core cycle.
// - 32-bit unit offers ring or linear mode; 16-bit unit is always ring.
// - 32-bit unit flags overflow and underflow.
// - while running, count rises by one or by step each tick.
// - with addition mode on, increments and decrements use the step value.
// - increment event adds step, or one when addition mode is off.
// - decrement event subtracts step, or one when addition mode is off.
// - each terminal with several sources uses the OR of them.
// - accepted load replaces count with the preset value.
// - capture strobe copies current count into the capture register.
// - capture from a plain event input happens on its rising edge.
// - software slot accepts word 1000 to 1099; writing it changes terminal state.
// - software word bit 0 requests go, bit 1 halt; other bits zero.
// - level terminals sampled each tick, so a steady high repeats events.
// - only highest priority acts: load, halt, go, increment, decrement.
// - losing go is held; load with go loads first, counts next tick.
// - each latch detector output is a single 0 or 1 bit.
// - edge detector drives its output high for exactly one cycle per edge.
// - counting clock period is selectable; fastest setting counts pulses correctly.
module edc_top #(
   parameter bit WIDE = 1'b0,
   parameter int SRC = 2,
   parameter int unsigned MS_CYC = edc_pkg::CYC_SEL6
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [2*SRC-1:0] GO_I,
   input wire logic [2*SRC-1:0] HALT_I,
   input wire logic [2*SRC-1:0] INC_I,
   input wire logic [2*SRC-1:0] DEC_I,
   input wire logic [2*SRC-1:0] LOAD_I,
   input wire logic [1:0] CAPT_EV_I,
   input wire logic [1:0] LATCH_IN_I,
   output logic [31:0] RD_DATA_O,
   output logic [1:0] CAPT_PULSE_O
);
   import edc_pkg::*;

   localparam int NU = WIDE ? 1 : 2;
   localparam int UW = WIDE ? 32 : 16;
   localparam int NI = 10 * SRC + 4;

   typedef struct packed {
      logic [15:0] slot0;
      logic [15:0] slot1;
      logic [1:0] gh0;
      logic [1:0] gh1;
      logic [7:0] ctrl;
      logic [31:0] step;
      logic [31:0] pre0;
      logic [31:0] pre1;
      logic [NI-1:0] sy1;
      logic [NI-1:0] sy2;
      logic [1:0] lat_prev;
      logic [1:0] cev_prev;
      logic [1:0] det;
      logic [15:0] div;
      logic tick;
      logic [31:0] rdata;
   } edc_tst_t;

   edc_tst_t s_r, s_nxt;
   logic [NI-1:0] pins;
   logic [2*SRC-1:0] go_s, halt_s, inc_s, dec_s, load_s;
   logic [1:0] cev_s, lat_s, cap_stb, sw_go, sw_halt, clr_ovf, clr_unf;
   logic [31:0] cnt_w [2];
   logic [31:0] cap_w [2];
   edc_stat_t st_w [2];
   edc_cfg_t cfg_w [2];
   edc_ev_t ev_w [2];
   logic wr_stat;

   function automatic logic slot_ok(input logic [15:0] v);
      return (v >= SLOT_MIN) && (v <= SLOT_MAX);
   endfunction : slot_ok

   function automatic logic [15:0] sel_reload(input logic [2:0] sel);
      case (sel)
         3'h1: return 16'(CYC_SEL1 - 1);
         3'h2: return 16'(CYC_SEL2 - 1);
         3'h3: return 16'(CYC_SEL3 - 1);
         3'h4: return 16'(CYC_SEL4 - 1);
         3'h5: return 16'(CYC_SEL5 - 1);
         3'h6: return 16'(MS_CYC - 1);
         default: return 16'(CYC_SEL0 - 1);
      endcase
   endfunction : sel_reload

   assign pins = {LATCH_IN_I, CAPT_EV_I, LOAD_I, DEC_I, INC_I, HALT_I, GO_I};
   assign {lat_s, cev_s, load_s, dec_s, inc_s, halt_s, go_s} = s_r.sy2;
   assign wr_stat = WR_I && ADDR_I == OFS_STAT;

   always_comb begin
      sw_go[0] = slot_ok(s_r.slot0) && s_r.gh0[GH_GO];
      sw_go[1] = slot_ok(s_r.slot1) && s_r.gh1[GH_GO];
      sw_halt[0] = slot_ok(s_r.slot0) && s_r.gh0[GH_HALT];
      sw_halt[1] = slot_ok(s_r.slot1) && s_r.gh1[GH_HALT];
      for (int i = 0; i < 2; i++) begin
         cap_stb[i] = s_r.det[i] | (cev_s[i] & ~s_r.cev_prev[i]);
         clr_ovf[i] = wr_stat && WDATA_I[4*i];
         clr_unf[i] = wr_stat && WDATA_I[4*i+1];
         cfg_w[i].en = s_r.ctrl[CTL_EN];
         cfg_w[i].ring = ~s_r.ctrl[CTL_LIN];
         cfg_w[i].add = s_r.ctrl[CTL_ADD];
         cfg_w[i].step = s_r.step;
         cfg_w[i].preset = (i == 0) ? s_r.pre0 : s_r.pre1;
         ev_w[i].load = |load_s[i*SRC +: SRC];
         ev_w[i].halt = (|halt_s[i*SRC +: SRC]) | sw_halt[i];
         ev_w[i].go = (|go_s[i*SRC +: SRC]) | sw_go[i];
         ev_w[i].inc = |inc_s[i*SRC +: SRC];
         ev_w[i].dec = |dec_s[i*SRC +: SRC];
         ev_w[i].capt = cap_stb[i];
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1 = pins;
      s_nxt.sy2 = s_r.sy1;
      s_nxt.lat_prev = lat_s;
      s_nxt.cev_prev = cev_s;
      for (int i = 0; i < 2; i++) begin
         s_nxt.det[i] = (s_r.ctrl[CTL_RISE] & lat_s[i] & ~s_r.lat_prev[i])
            | (s_r.ctrl[CTL_FALL] & ~lat_s[i] & s_r.lat_prev[i]);
      end
      if (s_r.div == 16'h0000) begin
         s_nxt.div = sel_reload(s_r.ctrl[CTL_SEL +: 3]);
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.div = s_r.div - 16'h0001;
         s_nxt.tick = 1'b0;
      end
      if (WR_I) begin
         case (ADDR_I)
            OFS_SLOT0: s_nxt.slot0 = WDATA_I[15:0];
            OFS_SLOT1: s_nxt.slot1 = WDATA_I[15:0];
            OFS_GH0: s_nxt.gh0 = WDATA_I[1:0];
            OFS_GH1: s_nxt.gh1 = WDATA_I[1:0];
            OFS_CTRL: s_nxt.ctrl = WDATA_I[7:0];
            OFS_STEP: s_nxt.step = WIDE ? WDATA_I : {16'h0000, WDATA_I[15:0]};
            OFS_PRE0: s_nxt.pre0 = WDATA_I;
            OFS_PRE1: s_nxt.pre1 = WDATA_I;
            default: s_nxt.slot0 = s_r.slot0;
         endcase
      end
      s_nxt.rdata = 32'h0000_0000;
      if (RD_I) begin
         case (ADDR_I)
            OFS_SLOT0: s_nxt.rdata = {16'h0000, s_r.slot0};
            OFS_SLOT1: s_nxt.rdata = {16'h0000, s_r.slot1};
            OFS_GH0: s_nxt.rdata = {30'h0000_0000, s_r.gh0};
            OFS_GH1: s_nxt.rdata = {30'h0000_0000, s_r.gh1};
            OFS_CTRL: s_nxt.rdata = {24'h00_0000, s_r.ctrl};
            OFS_STEP: s_nxt.rdata = s_r.step;
            OFS_PRE0: s_nxt.rdata = s_r.pre0;
            OFS_PRE1: s_nxt.rdata = s_r.pre1;
            OFS_CNT0: s_nxt.rdata = cnt_w[0];
            OFS_CNT1: s_nxt.rdata = cnt_w[1];
            OFS_CAP0: s_nxt.rdata = cap_w[0];
            OFS_CAP1: s_nxt.rdata = cap_w[1];
            OFS_STAT: s_nxt.rdata = {24'h00_0000, st_w[1], st_w[0]};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         s_r <= '{slot0: SLOT_RST, slot1: SLOT_RST, gh0: 2'h0, gh1: 2'h0, ctrl: CTRL_RST,
                  step: 32'h0000_0000, pre0: 32'h0000_0000, pre1: 32'h0000_0000,
                  sy1: '0, sy2: '0, lat_prev: 2'h0, cev_prev: 2'h0, det: 2'h0,
                  div: 16'h0000, tick: 1'b0, rdata: 32'h0000_0000};
      end else if (CE_I) begin
         s_r <= s_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_unit
         if (g < NU) begin : gen_on
            logic [UW-1:0] cnt_u, cap_u;
            edc_unit #(.W(UW)) u_cnt (
               .clk_i(CORE_CLK_I),
               .rst_i(RST_I),
               .ce_i(CE_I),
               .tick_i(s_r.tick),
               .cfg_i(cfg_w[g]),
               .ev_i(ev_w[g]),
               .clr_ovf_i(clr_ovf[g]),
               .clr_unf_i(clr_unf[g]),
               .cnt_o(cnt_u),
               .capt_o(cap_u),
               .stat_o(st_w[g])
            );
            assign cnt_w[g] = 32'(cnt_u);
            assign cap_w[g] = 32'(cap_u);
         end else begin : gen_off
            assign cnt_w[g] = 32'h0000_0000;
            assign cap_w[g] = 32'h0000_0000;
            assign st_w[g] = '0;
         end
      end
   endgenerate

   assign RD_DATA_O = s_r.rdata;
   assign CAPT_PULSE_O = s_r.det;

   AST_DET_PULSE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      CE_I && s_r.ctrl[CTL_RISE] && !s_r.ctrl[CTL_FALL] && CAPT_PULSE_O[0]
      ##1 CE_I && !s_r.ctrl[CTL_FALL] |-> !CAPT_PULSE_O[0]) else $error("rise pulse longer than one cycle");
   AST_CAPT_LINK: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      s_r.det[1] |-> ev_w[1].capt && (s_r.det[0] == ev_w[0].capt || cev_s[0])) else $error("latch link wrong");
   AST_SLOT_GATE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !slot_ok(s_r.slot0) |-> !sw_go[0] && !sw_halt[0]) else $error("software word acts without valid slot");
   AST_RD_ONE: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      CE_I && !RD_I |=> RD_DATA_O == 32'h0000_0000) else $error("read data outside read answer");
   AST_TICK_FAST: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      CE_I && s_r.ctrl[CTL_SEL +: 3] == 3'h0 && $stable(s_r.ctrl) && s_r.div == 16'h0000 |=> s_r.tick)
      else $error("fastest clock setting does not tick every cycle");
   COV_CAPT: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) CE_I && cap_stb[0]);
   COV_SW_HALT: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) CE_I && sw_halt[0] && s_r.tick);
endmodule : edc_top

// [edc_unit.sv]
/*
 * Shared constants and types, and one counter unit of the event driven up/down counter.
 * Assumes one core clock, an asynchronous active-high reset, a clock enable, and a
 * one-cycle counting tick and event levels already made in the core clock domain.
 */
package edc_pkg;
   localparam int unsigned CLK_NS = 40;
   localparam logic [7:0] OFS_SLOT0 = 8'h00;
   localparam logic [7:0] OFS_SLOT1 = 8'h04;
   localparam logic [7:0] OFS_GH0 = 8'h08;
   localparam logic [7:0] OFS_GH1 = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STEP = 8'h14;
   localparam logic [7:0] OFS_PRE0 = 8'h18;
   localparam logic [7:0] OFS_PRE1 = 8'h1C;
   localparam logic [7:0] OFS_CNT0 = 8'h20;
   localparam logic [7:0] OFS_CNT1 = 8'h24;
   localparam logic [7:0] OFS_CAP0 = 8'h28;
   localparam logic [7:0] OFS_CAP1 = 8'h2C;
   localparam logic [7:0] OFS_STAT = 8'h30;
   localparam int CTL_EN = 0;
   localparam int CTL_LIN = 1;
   localparam int CTL_ADD = 2;
   localparam int CTL_SEL = 3;
   localparam int CTL_RISE = 6;
   localparam int CTL_FALL = 7;
   localparam logic [7:0] CTRL_RST = 8'h03;
   localparam int GH_GO = 0;
   localparam int GH_HALT = 1;
   localparam logic [15:0] SLOT_MIN = 16'h03E8;
   localparam logic [15:0] SLOT_MAX = 16'h044B;
   localparam logic [15:0] SLOT_RST = 16'h0000;
   localparam int unsigned T_SEL0_NS = 25;
   localparam int unsigned T_SEL1_NS = 50;
   localparam int unsigned T_SEL2_NS = 100;
   localparam int unsigned T_SEL3_NS = 1000;
   localparam int unsigned T_SEL4_NS = 10000;
   localparam int unsigned T_SEL5_NS = 100000;
   localparam int unsigned T_SEL6_NS = 1000000;

   function automatic int unsigned edc_cyc(input int unsigned ns);
      return (ns / CLK_NS == 0) ? 1 : ns / CLK_NS;
   endfunction : edc_cyc

   localparam int unsigned CYC_SEL0 = edc_cyc(T_SEL0_NS);
   localparam int unsigned CYC_SEL1 = edc_cyc(T_SEL1_NS);
   localparam int unsigned CYC_SEL2 = edc_cyc(T_SEL2_NS);
   localparam int unsigned CYC_SEL3 = edc_cyc(T_SEL3_NS);
   localparam int unsigned CYC_SEL4 = edc_cyc(T_SEL4_NS);
   localparam int unsigned CYC_SEL5 = edc_cyc(T_SEL5_NS);
   localparam int unsigned CYC_SEL6 = edc_cyc(T_SEL6_NS);

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} edc_run_t;
   typedef struct packed {logic en; logic ring; logic add; logic [31:0] step; logic [31:0] preset;} edc_cfg_t;
   typedef struct packed {logic load; logic halt; logic go; logic inc; logic dec; logic capt;} edc_ev_t;
   typedef struct packed {logic ovf; logic unf; logic run; logic pend;} edc_stat_t;
endpackage : edc_pkg

module edc_unit #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire edc_pkg::edc_cfg_t cfg_i,
   input wire edc_pkg::edc_ev_t ev_i,
   input wire logic clr_ovf_i,
   input wire logic clr_unf_i,
   output logic [W-1:0] cnt_o,
   output logic [W-1:0] capt_o,
   output edc_pkg::edc_stat_t stat_o
);
   import edc_pkg::*;

   typedef struct packed {logic [W-1:0] cnt; logic [W-1:0] capt; edc_run_t run; logic pend; logic ovf; logic unf;} edc_ust_t;
   edc_ust_t s_r, s_nxt;
   logic [W-1:0] step;
   logic [W:0] up, dn;
   logic ring, act, do_up, do_dn;

   always_comb begin
      s_nxt = s_r;
      step = cfg_i.add ? cfg_i.step[W-1:0] : W'(1);
      up = {1'b0, s_r.cnt} + {1'b0, step};
      dn = {1'b0, s_r.cnt} - {1'b0, step};
      ring = (W != 32) || cfg_i.ring;
      act = tick_i && cfg_i.en;
      do_up = 1'b0;
      do_dn = 1'b0;
      if (clr_ovf_i) begin
         s_nxt.ovf = 1'b0;
      end
      if (clr_unf_i) begin
         s_nxt.unf = 1'b0;
      end
      if (ev_i.capt) begin
         s_nxt.capt = s_r.cnt;
      end
      if (act) begin
         if (ev_i.load) begin
            s_nxt.cnt = cfg_i.preset[W-1:0];
            s_nxt.pend = s_r.pend | ev_i.go;
         end else if (ev_i.halt) begin
            s_nxt.run = ST_IDLE;
            s_nxt.pend = ev_i.go;
         end else if (ev_i.go || s_r.pend) begin
            s_nxt.run = ST_RUN;
            s_nxt.pend = 1'b0;
            do_up = 1'b1;
         end else if (ev_i.inc) begin
            do_up = 1'b1;
         end else if (ev_i.dec) begin
            do_dn = 1'b1;
         end else begin
            case (s_r.run)
               ST_RUN: do_up = 1'b1;
               default: do_up = 1'b0;
            endcase
         end
      end
      if (do_up) begin
         s_nxt.cnt = (up[W] && !ring) ? {W{1'b1}} : up[W-1:0];
         if (up[W] && W == 32) begin
            s_nxt.ovf = 1'b1;
         end
      end
      if (do_dn) begin
         s_nxt.cnt = (dn[W] && !ring) ? {W{1'b0}} : dn[W-1:0];
         if (dn[W] && W == 32) begin
            s_nxt.unf = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '{cnt: '0, capt: '0, run: ST_IDLE, pend: 1'b0, ovf: 1'b0, unf: 1'b0};
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   assign cnt_o = s_r.cnt;
   assign capt_o = s_r.capt;
   assign stat_o = '{ovf: s_r.ovf, unf: s_r.unf, run: (s_r.run == ST_RUN), pend: s_r.pend};

   AST_LOAD_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && act && ev_i.load |=> s_r.cnt == $past(cfg_i.preset[W-1:0])) else $error("preset not loaded");
   AST_GO_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && act && ev_i.load && ev_i.go |=> s_r.pend) else $error("go lost under preset");
   AST_HALT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_r.run == ST_IDLE && !s_r.pend && !ev_i.load && !ev_i.go && !ev_i.inc && !ev_i.dec
      |=> s_r.cnt == $past(s_r.cnt)) else $error("count moved while halted");
   AST_INC_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && act && ev_i.inc && !ev_i.load && !ev_i.halt && !ev_i.go && !s_r.pend && !up[W]
      |=> s_r.cnt == $past(up[W-1:0])) else $error("increment wrong");
   AST_DEC_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && act && ev_i.dec && !ev_i.inc && !ev_i.load && !ev_i.halt && !ev_i.go && !s_r.pend
      && s_r.run == ST_IDLE && !dn[W] |=> s_r.cnt == $past(dn[W-1:0])) else $error("decrement wrong");
   AST_CAPT_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ev_i.capt |=> s_r.capt == $past(s_r.cnt)) else $error("capture wrong");
   AST_OVF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && do_up && up[W] && W == 32 |=> s_r.ovf) else $error("overflow not flagged");
   AST_UNF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && do_dn && dn[W] && W == 32 |=> s_r.unf) else $error("underflow not flagged");
   COV_LOAD_GO: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && act && ev_i.load && ev_i.go);
   COV_OVF: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && do_up && up[W]);
endmodule : edc_unit

// [edc_nbr_model.sv]
/*
 * Model of the neighbouring event logic that drives the counter's event, capture and latch pins.
 * Assumes the core clock; every pin changes by non-blocking assignment right after a rising edge.
 */
module edc_nbr_model #(
   parameter int SRC = 2
) (
   input wire logic clk_i,
   output logic [2*SRC-1:0] go_o,
   output logic [2*SRC-1:0] halt_o,
   output logic [2*SRC-1:0] inc_o,
   output logic [2*SRC-1:0] dec_o,
   output logic [2*SRC-1:0] load_o,
   output logic [1:0] capt_o,
   output logic [1:0] latch_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      go_o = '0;
      halt_o = '0;
      inc_o = '0;
      dec_o = '0;
      load_o = '0;
      capt_o = '0;
      latch_o = '0;
   end

   // Drives a set of sources for n cycles, then releases them low; several at once only on request
   task automatic fire(input logic [2*SRC-1:0] go, input logic [2*SRC-1:0] halt, input logic [2*SRC-1:0] inc,
                       input logic [2*SRC-1:0] dec, input logic [2*SRC-1:0] load, input logic [1:0] capt,
                       input int n);
      @(posedge clk_i);
      go_o <= go;
      halt_o <= halt;
      inc_o <= inc;
      dec_o <= dec;
      load_o <= load;
      capt_o <= capt;
      repeat (n) @(posedge clk_i);
      go_o <= '0;
      halt_o <= '0;
      inc_o <= '0;
      dec_o <= '0;
      load_o <= '0;
      capt_o <= '0;
   endtask : fire

   // Sets the latch detector input levels
   task automatic latch(input logic [1:0] v);
      @(posedge clk_i);
      latch_o <= v;
   endtask : latch
endmodule : edc_nbr_model

// [edc_tb.sv]
/*
 * Self-checking testbench of the event driven up/down counter, 16-bit build with two units
 * beside a 32-bit build with one unit on the same bus and pins.
 * Assumes the fastest counting clock setting, which gives a tick on every core cycle.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import edc_pkg::*;

   logic CORE_CLK_I, RST_I, CE_I, WR_I, RD_I;
   logic [7:0] ADDR_I;
   logic [31:0] WDATA_I, RD_DATA_O, RD_W, a, b, c, w;
   logic [3:0] GO_I, HALT_I, INC_I, DEC_I, LOAD_I;
   logic [1:0] CAPT_EV_I, LATCH_IN_I, CAPT_PULSE_O;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int pulses = 0;

   edc_top #(.WIDE(1'b0), .SRC(2), .MS_CYC(20)) dut (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .GO_I(GO_I), .HALT_I(HALT_I),
      .INC_I(INC_I), .DEC_I(DEC_I), .LOAD_I(LOAD_I), .CAPT_EV_I(CAPT_EV_I), .LATCH_IN_I(LATCH_IN_I),
      .RD_DATA_O(RD_DATA_O), .CAPT_PULSE_O(CAPT_PULSE_O));

   edc_top #(.WIDE(1'b1), .SRC(2), .MS_CYC(20)) dut_wide (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CE_I(CE_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .GO_I(GO_I), .HALT_I(HALT_I),
      .INC_I(INC_I), .DEC_I(DEC_I), .LOAD_I(LOAD_I), .CAPT_EV_I(CAPT_EV_I), .LATCH_IN_I(LATCH_IN_I),
      .RD_DATA_O(RD_W), .CAPT_PULSE_O());

   edc_nbr_model #(.SRC(2)) ev (.clk_i(CORE_CLK_I), .go_o(GO_I), .halt_o(HALT_I), .inc_o(INC_I),
      .dec_o(DEC_I), .load_o(LOAD_I), .capt_o(CAPT_EV_I), .latch_o(LATCH_IN_I));

   initial begin
      CORE_CLK_I = 1'b0;
      forever #20 CORE_CLK_I = ~CORE_CLK_I;
   end

   always @(negedge CORE_CLK_I) begin
      cyc++;
      if (CAPT_PULSE_O[1] === 1'b1) pulses++;
      if (cyc == 6000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (err_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge CORE_CLK_I);
      WR_I <= 1'b1;
      ADDR_I <= ad;
      WDATA_I <= d;
      @(posedge CORE_CLK_I);
      WR_I <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] v);
      @(posedge CORE_CLK_I);
      RD_I <= 1'b1;
      ADDR_I <= ad;
      @(posedge CORE_CLK_I);
      RD_I <= 1'b0;
      #1 v = RD_DATA_O;
      w = RD_W;
   endtask : rd

   // Reads a register after the pins have settled through synchronisers and a tick
   task automatic rdc(input string what, input logic [7:0] ad, input logic [31:0] exp);
      logic [31:0] v;
      repeat (6) @(posedge CORE_CLK_I);
      rd(ad, v);
      chk(what, exp, v);
   endtask : rdc

   // Counts advance over ten cycles between two reads of count 0
   task automatic gap(input string what, input logic [31:0] exp);
      rd(OFS_CNT0, a);
      repeat (8) @(posedge CORE_CLK_I);
      rd(OFS_CNT0, b);
      chk(what, exp, b - a);
   endtask : gap

   initial begin
      RST_I = 1'b1;
      CE_I = 1'b1;
      WR_I = 1'b0;
      RD_I = 1'b0;
      ADDR_I = 8'h00;
      WDATA_I = 32'h00000000;
      repeat (2) @(posedge CORE_CLK_I);
      RST_I <= 1'b0;
      rdc("ctrl reset", OFS_CTRL, 32'h00000003);
      rdc("slot reset", OFS_SLOT0, 32'h00000000);
      rdc("unmapped", 8'hFC, 32'h00000000);
      wr(OFS_CTRL, 32'h00000041);
      ev.fire(4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 2'h0, 1);
      rdc("inc src1", OFS_CNT0, 32'h00000001);
      rdc("unit1 idle", OFS_CNT1, 32'h00000000);
      wr(OFS_STEP, 32'h00000005);
      wr(OFS_CTRL, 32'h00000045);
      ev.fire(4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 2'h0, 1);
      rdc("inc step", OFS_CNT0, 32'h00000006);
      ev.fire(4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 2'h0, 1);
      rdc("dec step", OFS_CNT0, 32'h00000001);
      wr(OFS_CTRL, 32'h00000043);
      ev.fire(4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 2'h0, 1);
      rdc("dec one", OFS_CNT0, 32'h00000000);
      ev.fire(4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 2'h0, 1);
      rdc("ring wrap", OFS_CNT0, 32'h0000FFFF);
      chk("linear floor", 32'h00000000, w);
      rdc("no flag 16", OFS_STAT, 32'h00000000);
      chk("underflow flag", 32'h00000004, w);
      wr(OFS_STAT, 32'h00000002);
      rdc("flag clear", OFS_STAT, 32'h00000000);
      chk("underflow clear", 32'h00000000, w);
      wr(OFS_PRE0, 32'h00000064);
      ev.fire(4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 2'h0, 1);
      rdc("load over inc", OFS_CNT0, 32'h00000064);
      ev.fire(4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 2'h0, 1);
      rdc("halt over inc", OFS_CNT0, 32'h00000064);
      ev.fire(4'h1, 4'h0, 4'h0, 4'h0, 4'h1, 2'h0, 1);
      rdc("go held", OFS_STAT, 32'h00000002);
      gap("run rate", 32'h0000000A);
      ev.fire(4'h0, 4'h2, 4'h0, 4'h0, 4'h0, 2'h0, 1);
      rdc("halted", OFS_STAT, 32'h00000000);
      gap("halt hold", 32'h00000000);
      ev.fire(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 2'h1, 1);
      rdc("capture ev", OFS_CAP0, b);
      ev.fire(4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 2'h0, 1);
      ev.latch(2'b10);
      rdc("latch 1", OFS_CAP1, 32'h00000001);
      chk("wide no unit1", 32'h00000000, w);
      rdc("unit0 cap kept", OFS_CAP0, b);
      ev.latch(2'b00);
      repeat (6) @(posedge CORE_CLK_I);
      chk("pulse count", 32'h00000001, pulses);
      wr(OFS_SLOT0, 32'h000003E7);
      wr(OFS_GH0, 32'h00000001);
      gap("slot invalid", 32'h00000000);
      wr(OFS_SLOT0, 32'h0000044B);
      gap("soft go", 32'h0000000A);
      rd(OFS_CNT0, a);
      @(posedge CORE_CLK_I);
      CE_I <= 1'b0;
      repeat (20) @(posedge CORE_CLK_I);
      CE_I <= 1'b1;
      rd(OFS_CNT0, b);
      chk("enable freeze", 32'h00000003, b - a);
      wr(OFS_GH0, 32'h00000002);
      gap("soft halt", 32'h00000000);
      wr(OFS_GH0, 32'h00000000);
      rd(OFS_CNT0, c);
      ev.fire(4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 2'h0, 4);
      rdc("level repeat", OFS_CNT0, c + 32'h00000004);
      @(posedge CORE_CLK_I);
      RST_I <= 1'b1;
      @(posedge CORE_CLK_I);
      RST_I <= 1'b0;
      rdc("count reset", OFS_CNT0, 32'h00000000);
      rdc("ctrl reset again", OFS_CTRL, 32'h00000003);
      stop_test();
   end
endmodule : testbench
